// *** common/mmu_cmd_pkg.sv ***
package mmu_cmd_pkg;

   // ***************************************
   // register map (index, byte address = 4 * index)
   // ***************************************
   localparam int unsigned ADDR_W   = 12;
   localparam logic [9:0]  IDX_CMD  = 10'h000;
   localparam logic [9:0]  IDX_NUM  = 10'h002;
   localparam logic [9:0]  IDX_RES  = 10'h003;
   localparam logic [9:0]  IDX_QUE  = 10'h004;
   localparam logic [9:0]  IDX_CTL  = 10'h005;

   // ***************************************
   // field positions and reset values
   // ***************************************
   localparam int unsigned BUSY_BIT   = 0;
   localparam int unsigned OP_LSB     = 5;
   localparam int unsigned FAILED_BIT = 7;
   localparam int unsigned RXEMP_BIT  = 15;
   localparam int unsigned RXPKT_LSB  = 8;
   localparam int unsigned CMEMP_BIT  = 7;
   localparam int unsigned RXSEL_BIT  = 0;
   localparam logic [5:0]  NUM_RST    = 6'h00;
   localparam logic        FAILED_RST = 1'b1;

   // ***************************************
   // sizes and cycle counts
   // ***************************************
   localparam int unsigned PKT_W       = 6;
   localparam int unsigned NUM_PKT     = 16;
   localparam int unsigned Q_DEPTH     = 4;
   localparam logic [3:0]  ALLOC_CYC   = 4'h2;
   localparam logic [3:0]  RELEASE_CYC = 4'h4;

   typedef enum logic [2:0] {
      OP_NOP   = 3'b000,
      OP_ALLOC = 3'b001,
      OP_RESET = 3'b010,
      OP_RXPOP = 3'b011,
      OP_RXREL = 3'b100,
      OP_REL   = 3'b101,
      OP_TXENQ = 3'b110,
      OP_TXRST = 3'b111
   } mmu_op_e;

   typedef enum logic [1:0] {
      Q_RX  = 2'b00,
      Q_TXP = 2'b01,
      Q_CMP = 2'b10
   } queue_id_e;

   typedef enum logic [1:0] {
      AL_IDLE = 2'b00,
      AL_WAIT = 2'b01,
      AL_PEND = 2'b10
   } alloc_st_e;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef struct packed {
      logic [Q_DEPTH-1:0][PKT_W-1:0] ent;
      logic [1:0]                    rd;
      logic [2:0]                    cnt;
   } pkt_queue_s;

   typedef struct packed {
      apb_rsp_s              rsp;
      pkt_queue_s [2:0]      q;
      logic [NUM_PKT-1:0]    used_map;
      logic [PKT_W-1:0]      pkt_num;
      logic                  rx_sel;
      logic                  failed;
      logic [PKT_W-1:0]      alloc_pkt;
      logic                  alloc_ok;
      alloc_st_e             al_st;
      logic [3:0]            al_cnt;
      logic                  busy;
      logic [3:0]            rel_cnt;
      logic [PKT_W-1:0]      rel_pkt;
      logic                  rx_int;
      logic [PKT_W-1:0]      buf_pkt;
      logic                  tx_pend;
      logic [PKT_W-1:0]      tx_head;
   } mmu_state_s;

endpackage

// *** design/mmu_cmd.sv ***
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module mmu_cmd
   import mmu_cmd_pkg::*;
(
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire apb_req_s         apb_in,
   output apb_rsp_s              apb_out,
   input  wire logic             rx_push_in,
   input  wire logic [PKT_W-1:0] rx_pkt_in,
   input  wire logic             tx_take_in,
   input  wire logic             tx_done_in,
   input  wire logic [PKT_W-1:0] tx_done_pkt_in,
   output logic                  rx_int_out,
   output logic                  alloc_ok_out,
   output logic                  busy_out,
   output logic [PKT_W-1:0]      buf_pkt_out,
   output logic                  tx_pend_out,
   output logic [PKT_W-1:0]      tx_head_out
);

   mmu_state_s       st;
   mmu_state_s       nxt;
   logic [9:0]       idx;
   logic             acc;
   logic             wr;
   mmu_op_e          wop;
   logic             cmd_wr;
   logic [2:0]       push;
   logic [2:0]       pop;
   logic [2:0]       clr;
   logic [PKT_W-1:0] pdat [3];
   logic [PKT_W:0]   ff;

   // lowest free packet, msb flags that one exists
   function automatic logic [PKT_W:0] first_free(input logic [NUM_PKT-1:0] used);
      logic [PKT_W:0] r;
      r = '0;
      for (int i = NUM_PKT - 1; i >= 0; i--) begin
         if (!used[i]) begin
            r = {1'b1, PKT_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [PKT_W-1:0] head(input pkt_queue_s qq);
      return qq.ent[qq.rd];
   endfunction

   assign idx    = apb_in.paddr[ADDR_W-1:2];
   assign acc    = apb_in.psel & apb_in.penable & st.rsp.pready;
   assign wr     = acc & apb_in.pwrite;
   assign wop    = mmu_op_e'(apb_in.pwdata[OP_LSB +: 3]);
   assign cmd_wr = wr & (idx == IDX_CMD);

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      nxt  = st;
      push = '0;
      pop  = '0;
      clr  = '0;
      pdat[Q_RX]  = rx_pkt_in;
      pdat[Q_TXP] = st.pkt_num;
      pdat[Q_CMP] = tx_done_pkt_in;
      ff   = '0;

      // bus slave: one wait-free access phase, data fetched in setup
      nxt.rsp.pready  = apb_in.psel & ~apb_in.penable;
      nxt.rsp.pslverr = 1'b0;
      nxt.rsp.prdata  = '0;
      if (apb_in.psel & ~apb_in.penable) begin
         case (idx)
            IDX_CMD: nxt.rsp.prdata[BUSY_BIT] = st.busy;
            IDX_NUM: nxt.rsp.prdata[PKT_W-1:0] = st.pkt_num;
            IDX_RES: begin
               nxt.rsp.prdata[FAILED_BIT]  = st.failed;
               nxt.rsp.prdata[PKT_W-1:0]   = st.alloc_pkt;
            end
            IDX_QUE: begin
               nxt.rsp.prdata[RXEMP_BIT]              = st.q[Q_RX].cnt == 3'h0;
               nxt.rsp.prdata[RXPKT_LSB +: PKT_W]     = head(st.q[Q_RX]);
               nxt.rsp.prdata[CMEMP_BIT]              = st.q[Q_CMP].cnt == 3'h0;
               nxt.rsp.prdata[PKT_W-1:0]              = head(st.q[Q_CMP]);
            end
            IDX_CTL: nxt.rsp.prdata[RXSEL_BIT] = st.rx_sel;
            default: nxt.rsp.pslverr = 1'b1;
         endcase
      end

      // outside events
      push[Q_RX]  = rx_push_in;
      pop[Q_TXP]  = tx_take_in & (st.q[Q_TXP].cnt != 3'h0);
      push[Q_CMP] = tx_done_in;

      // release engine; freeing waits out the busy time
      if (st.busy) begin
         nxt.rel_cnt = st.rel_cnt - 4'h1;
         if (st.rel_cnt == 4'h1) begin
            nxt.busy = 1'b0;
            nxt.used_map[st.rel_pkt[3:0]] = 1'b0;
         end
      end

      // allocation engine; stays pending until a page frees
      case (st.al_st)
         AL_IDLE: nxt.al_st = AL_IDLE;
         AL_WAIT: begin
            nxt.al_cnt = st.al_cnt - 4'h1;
            if (st.al_cnt == 4'h1) begin
               nxt.al_st = AL_PEND;
            end
         end
         AL_PEND: begin
            ff = first_free(nxt.used_map);
            if (ff[PKT_W]) begin
               nxt.used_map[ff[3:0]] = 1'b1;
               nxt.alloc_pkt = ff[PKT_W-1:0];
               nxt.failed    = 1'b0;
               nxt.alloc_ok  = 1'b1;
               nxt.al_st     = AL_IDLE;
            end
         end
         default: nxt.al_st = AL_IDLE;
      endcase

      // register writes
      if (wr) begin
         case (idx)
            IDX_NUM: nxt.pkt_num = apb_in.pwdata[PKT_W-1:0];
            IDX_QUE: pop[Q_CMP] = st.q[Q_CMP].cnt != 3'h0;
            IDX_CTL: nxt.rx_sel = apb_in.pwdata[RXSEL_BIT];
            default: nxt.rx_sel = nxt.rx_sel;
         endcase
      end

      // commands take effect at the end of the write access
      if (cmd_wr) begin
         case (wop)
            OP_NOP: nxt.rx_sel = nxt.rx_sel;
            OP_ALLOC: begin
               nxt.failed    = 1'b1;
               nxt.alloc_ok  = 1'b0;
               nxt.al_st     = AL_WAIT;
               nxt.al_cnt    = ALLOC_CYC;
            end
            OP_RXPOP: pop[Q_RX] = st.q[Q_RX].cnt != 3'h0;
            OP_RXREL: begin
               if (st.q[Q_RX].cnt != 3'h0) begin
                  pop[Q_RX]   = 1'b1;
                  nxt.rel_pkt = head(st.q[Q_RX]);
                  nxt.busy    = 1'b1;
                  nxt.rel_cnt = RELEASE_CYC;
               end
            end
            OP_REL: begin
               nxt.rel_pkt = st.pkt_num;
               nxt.busy    = 1'b1;
               nxt.rel_cnt = RELEASE_CYC;
            end
            OP_TXENQ: push[Q_TXP] = 1'b1;
            OP_TXRST: begin
               clr[Q_TXP] = 1'b1;
               clr[Q_CMP] = 1'b1;
            end
            OP_RESET: begin
               clr           = 3'b111;
               nxt.used_map  = '0;
               nxt.failed    = FAILED_RST;
               nxt.alloc_ok  = 1'b0;
               nxt.al_st     = AL_IDLE;
               nxt.busy      = 1'b0;
               nxt.pkt_num   = NUM_RST;
            end
            default: nxt.rx_sel = nxt.rx_sel;
         endcase
      end

      // queue update, a full queue drops the push unless it pops in the same cycle
      for (int k = 0; k < 3; k++) begin
         if (clr[k]) begin
            nxt.q[k].rd  = 2'h0;
            nxt.q[k].cnt = 3'h0;
         end else begin
            if (pop[k]) begin
               nxt.q[k].rd  = 2'(st.q[k].rd + 2'h1);
               nxt.q[k].cnt = st.q[k].cnt - 3'h1;
            end
            if (push[k] && (st.q[k].cnt != 3'(Q_DEPTH) || pop[k])) begin
               nxt.q[k].ent[2'(st.q[k].rd + st.q[k].cnt[1:0])] = pdat[k];
               nxt.q[k].cnt = nxt.q[k].cnt + 3'h1;
            end
         end
      end

      nxt.rx_int  = nxt.q[Q_RX].cnt != 3'h0;
      nxt.buf_pkt = nxt.rx_sel ? head(nxt.q[Q_RX]) : nxt.pkt_num;
      nxt.tx_pend = nxt.q[Q_TXP].cnt != 3'h0;
      nxt.tx_head = head(nxt.q[Q_TXP]);
   end

   // ***************************************
   // state register
   // ***************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st        <= '0;
         st.failed <= FAILED_RST;
         st.pkt_num <= NUM_RST;
      end else if (ce_in) begin
         st <= nxt;
      end
   end

   assign apb_out       = st.rsp;
   assign rx_int_out    = st.rx_int;
   assign alloc_ok_out  = st.alloc_ok;
   assign busy_out      = st.busy;
   assign buf_pkt_out   = st.buf_pkt;
   assign tx_pend_out   = st.tx_pend;
   assign tx_head_out   = st.tx_head;

   // ***************************************
   // checks
   // ***************************************
   chk_nop_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_NOP && !rx_push_in && !tx_take_in && !tx_done_in
      && !st.busy && st.al_st == AL_IDLE
      |=> $stable(st.used_map) && $stable(st.q) && $stable(st.failed))
      else $error("noop changed manager state");

   chk_reset_cmd: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_RESET
      |=> st.used_map == '0 && st.pkt_num == NUM_RST && st.failed && !st.busy
      && st.q[Q_TXP].cnt == 3'h0 && !st.alloc_ok)
      else $error("manager reset incomplete");

   chk_rx_pop: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_RXPOP && st.q[Q_RX].cnt != 3'h0 && !rx_push_in
      |=> st.q[Q_RX].cnt == $past(st.q[Q_RX].cnt) - 3'h1 && !st.busy)
      else $error("receive pop wrong");

   chk_rx_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      st.rx_int == (st.q[Q_RX].cnt != 3'h0))
      else $error("receive flag disagrees with queue");

   chk_release_time: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_REL && !st.busy
      // a pending allocation may take the freed page in the same cycle
      |=> st.busy[*4] ##1 (!st.busy && (!st.used_map[$past(st.pkt_num[3:0], 5)]
      || ($rose(st.alloc_ok) && st.alloc_pkt == $past(st.pkt_num, 5)))))
      else $error("release did not free in time");

   chk_tx_enqueue: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_TXENQ && !tx_take_in && st.q[Q_TXP].cnt == 3'h0
      |=> st.tx_pend ##1 st.tx_head == $past(st.pkt_num, 2))
      else $error("enqueue lost packet");

   chk_tx_reset: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_TXRST && !st.busy && st.al_st == AL_IDLE
      |=> st.q[Q_TXP].cnt == 3'h0 && st.q[Q_CMP].cnt == 3'h0 && $stable(st.used_map))
      else $error("transmit queue reset wrong");

   chk_busy_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && (wop == OP_REL || (wop == OP_RXREL && st.q[Q_RX].cnt != 3'h0))
      |=> st.busy)
      else $error("busy not set by release");

   chk_alloc_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in || !ce_in)
      cmd_wr && wop == OP_ALLOC && st.al_st == AL_IDLE && !st.busy && st.used_map != '1
      |=> st.failed ##3 (!st.failed && st.alloc_ok && st.used_map[st.alloc_pkt[3:0]]))
      else $error("allocation result wrong");

   chk_buf_select: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      st.buf_pkt == (st.rx_sel ? head(st.q[Q_RX]) : st.pkt_num))
      else $error("buffer packet select wrong");

endmodule // mmu_cmd

`default_nettype wire

// *** test/mmu_cmd_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module mmu_cmd_tb_top
   import mmu_cmd_pkg::*;
   ;
   logic mclk, rst_n, ce, rx_push, tx_take, tx_done, rx_int, alloc_ok, busy, tx_pend;
   logic [5:0] rx_pkt, tx_done_pkt, buf_pkt, tx_head;
   logic [5:0] pk [16];
   apb_req_s   req;
   apb_rsp_s   rsp;
   int         fails, total_checks;

   mmu_cmd dut (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .apb_in(req), .apb_out(rsp),
      .rx_push_in(rx_push), .rx_pkt_in(rx_pkt), .tx_take_in(tx_take), .tx_done_in(tx_done),
      .tx_done_pkt_in(tx_done_pkt), .rx_int_out(rx_int), .alloc_ok_out(alloc_ok),
      .busy_out(busy), .buf_pkt_out(buf_pkt), .tx_pend_out(tx_pend), .tx_head_out(tx_head));
   mmu_host_model host (.mclk_in(mclk), .rsp_in(rsp), .req_out(req));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ***************************************
   // helpers
   // ***************************************
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [9:0] idx, output logic [31:0] d);
      logic e;
      host.xfer(1'b0, idx, 32'h0, d, e);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] x;
      logic        e;
      host.xfer(1'b1, idx, d, x, e);
   endtask

   task automatic settle;
      @(posedge mclk);
      #1;
   endtask

   task automatic wait_idle;
      logic [31:0] d;
      int n;
      n = 0;
      do begin
         rd(IDX_CMD, d);
         n++;
      end while (d[BUSY_BIT] !== 1'b0 && n < 20);
      chk(d[BUSY_BIT], 1'b0);
   endtask

   task automatic cmd(input mmu_op_e op);
      wr(IDX_CMD, {24'h0, op, 5'h00});
      wait_idle();
   endtask

   task automatic wait_arr(output logic [5:0] p);
      logic [31:0] d;
      int n;
      n = 0;
      do begin
         rd(IDX_RES, d);
         n++;
      end while (d[FAILED_BIT] !== 1'b0 && n < 12);
      chk(d[FAILED_BIT], 1'b0);
      p = d[5:0];
   endtask

   // which: 0 receive push, 1 completion push, 2 transmitter take
   task automatic pulse(input int which, input logic [5:0] p);
      @(posedge mclk);
      rx_push <= (which == 0);
      tx_done <= (which == 1);
      tx_take <= (which == 2);
      rx_pkt <= p;
      tx_done_pkt <= p;
      @(posedge mclk);
      rx_push <= 1'b0;
      tx_done <= 1'b0;
      tx_take <= 1'b0;
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset_state;
      logic [31:0] d;
      logic        e;
      rd(IDX_RES, d);
      chk(d[FAILED_BIT], 1'b1);
      rd(IDX_NUM, d);
      chk(d, 32'h0);
      host.xfer(1'b0, 10'h3FF, 32'h0, d, e);
      chk(e, 1'b1);
      wr(IDX_RES, 32'h0);
      rd(IDX_RES, d);
      chk(d[FAILED_BIT], 1'b1);
      wr(IDX_CMD, 32'hFFFF_FF1F);
      settle();
      chk({busy, alloc_ok, tx_pend}, 3'h0);
      $display("test reset_state done");
   endtask

   task automatic t_alloc_all;
      logic [15:0] used;
      logic [31:0] d;
      logic [5:0]  p;
      used = '0;
      for (int i = 0; i < 16; i++) begin
         cmd(OP_ALLOC);
         wait_arr(p);
         chk(p < 6'h10 && !used[p[3:0]], 1'b1);
         chk(alloc_ok, 1'b1);
         used[p[3:0]] = 1'b1;
         pk[i] = p;
      end
      // memory full: this request stays pending
      cmd(OP_ALLOC);
      repeat (6) settle();
      rd(IDX_RES, d);
      chk({d[FAILED_BIT], alloc_ok}, 2'b10);
      $display("test alloc_all done");
   endtask

   task automatic t_rx_release;
      logic [31:0] d;
      logic [5:0]  p;
      pulse(0, pk[0]);
      pulse(0, pk[1]);
      wr(IDX_CTL, 32'h1);
      settle();
      chk({rx_int, buf_pkt}, {1'b1, pk[0]});
      cmd(OP_RXPOP);
      settle();
      chk({rx_int, buf_pkt}, {1'b1, pk[1]});
      rd(IDX_RES, d);
      chk(d[FAILED_BIT], 1'b1);
      wr(IDX_CMD, {24'h0, OP_RXREL, 5'h00});
      settle();
      chk(busy, 1'b1);
      rd(IDX_CMD, d);
      chk(d[BUSY_BIT], 1'b1);
      wait_idle();
      chk(rx_int, 1'b0);
      wait_arr(p);
      chk(p, pk[1]);
      wr(IDX_NUM, {26'h0, pk[0]});
      wr(IDX_CMD, {24'h0, OP_REL, 5'h00});
      settle();
      chk(busy, 1'b1);
      wait_idle();
      cmd(OP_ALLOC);
      wait_arr(p);
      chk(p, pk[0]);
      $display("test rx_release done");
   endtask

   task automatic t_tx;
      logic [31:0] d;
      logic [5:0]  p;
      wr(IDX_CTL, 32'h0);
      wr(IDX_NUM, {26'h0, pk[2]});
      settle();
      chk(buf_pkt, pk[2]);
      cmd(OP_TXENQ);
      chk({tx_pend, tx_head}, {1'b1, pk[2]});
      wr(IDX_NUM, {26'h0, pk[3]});
      cmd(OP_TXENQ);
      pulse(2, 6'h00);
      settle();
      chk({tx_pend, tx_head}, {1'b1, pk[3]});
      pulse(1, pk[2]);
      rd(IDX_QUE, d);
      chk({d[CMEMP_BIT], d[5:0]}, {1'b0, pk[2]});
      cmd(OP_TXRST);
      chk(tx_pend, 1'b0);
      rd(IDX_QUE, d);
      chk(d[CMEMP_BIT], 1'b1);
      cmd(OP_ALLOC);
      repeat (6) settle();
      rd(IDX_RES, d);
      chk(d[FAILED_BIT], 1'b1);
      cmd(OP_REL);
      wait_arr(p);
      chk(p, pk[3]);
      $display("test tx done");
   endtask

   task automatic t_mmu_reset;
      logic [31:0] d;
      logic [5:0]  p;
      wr(IDX_NUM, 32'h5);
      pulse(0, pk[4]);
      cmd(OP_RESET);
      chk({rx_int, alloc_ok, tx_pend}, 3'h0);
      rd(IDX_NUM, d);
      chk(d, 32'h0);
      rd(IDX_RES, d);
      chk(d[FAILED_BIT], 1'b1);
      cmd(OP_ALLOC);
      wait_arr(p);
      $display("test mmu_reset done");
   endtask

   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      {rst_n, rx_push, tx_take, tx_done} = '0;
      {rx_pkt, tx_done_pkt} = '0;
      ce = 1'b1;
      fails = 0;
      total_checks = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset_state();
      t_alloc_all();
      t_rx_release();
      t_tx();
      t_mmu_reset();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      complete_run();
   end
endmodule // mmu_cmd_tb_top

`default_nettype wire

// *** test/mmu_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module mmu_host_model
   import mmu_cmd_pkg::*;
(
   input  wire logic     mclk_in,
   input  wire apb_rsp_s rsp_in,
   output apb_req_s      req_out
);
   initial req_out = '0;

   // ***************************************
   // one apb transfer, held until pready
   // ***************************************
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge mclk_in);
      req_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
      @(posedge mclk_in);
      req_out.penable <= 1'b1;
      // no own limit: the bench watchdog ends a dead wait
      do begin
         @(posedge mclk_in);
      end while (rsp_in.pready !== 1'b1);
      rd = rsp_in.prdata;
      err = rsp_in.pslverr;
      req_out <= '0;
   endtask
endmodule // mmu_host_model

`default_nettype wire
